// [src/tlc_pkg.sv]
package tlc_pkg;

  // ===========================================================================
  // Clock and qualification timing
  // ===========================================================================
  localparam longint unsigned CLK_HZ           = 64'd250_000_000;
  localparam longint unsigned LOOP_QUAL_S      = 64'd5;
  localparam longint unsigned LOOP_QUAL_CYC_L  = LOOP_QUAL_S * CLK_HZ;
  localparam logic [31:0]     LOOP_QUAL_CYCLES = 32'(LOOP_QUAL_CYC_L);

  // ===========================================================================
  // Register bus and map
  // ===========================================================================
  localparam int unsigned ADDR_W        = 16;
  localparam int unsigned DATA_W        = 8;
  localparam logic [15:0] ADDR_LINE_CFG = 16'h0f02;
  localparam logic [15:0] ADDR_CTRL3    = 16'h0f03;
  localparam logic [15:0] ADDR_IRQ_EN   = 16'h0f04;
  localparam logic [15:0] ADDR_STATUS   = 16'h0f05;
  localparam logic [15:0] ADDR_IRQ_STS  = 16'h0f06;
  localparam logic [7:0]  RST_VAL       = 8'h00;
  localparam logic [7:0]  RDATA_IDLE    = 8'h00;

  // ===========================================================================
  // Field layout
  // ===========================================================================
  localparam int unsigned CTRL3_DET_SEL_LSB = 6;
  localparam int unsigned CTRL3_LINE_CODE   = 5;
  localparam int unsigned CTRL3_INS_ERR     = 1;
  localparam int unsigned CFG_SINGLE_RAIL   = 3;
  localparam logic [7:0]  CFG_MASK          = 8'h0f;
  localparam int unsigned LOOP_BIT          = 3;
  localparam logic [7:0]  LOOP_MASK         = 8'h08;

  // ===========================================================================
  // Patterns and encodings
  // ===========================================================================
  localparam int unsigned LOOP_UP_PERIOD   = 5;
  localparam int unsigned LOOP_DOWN_PERIOD = 3;
  localparam logic [2:0]  PAT_QRSS         = 3'h4;

  typedef enum logic [1:0] {
    DET_OFF  = 2'h0,
    DET_UP   = 2'h1,
    DET_DOWN = 2'h2,
    DET_AUTO = 2'h3
  } tlc_det_sel_e;

  typedef enum logic [1:0] {
    AUTO_OFF    = 2'h0,
    AUTO_HUNT   = 2'h1,
    AUTO_LOOPED = 2'h3
  } tlc_auto_e;

endpackage

// [src/tlc_pattern_det.sv]
`timescale 1ns/1ps
module tlc_pattern_det #(
  parameter int unsigned PERIOD = 5
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Receive bit stream
  input  wire logic en_i,
  input  wire logic bit_valid_i,
  input  wire logic bit_i,
  // Result
  output logic      match_o
);

  typedef struct packed {
    logic [PERIOD-1:0] hist;
    logic              match;
  } tlc_det_state_s;

  tlc_det_state_s q;
  tlc_det_state_s d;

  // A repeating pattern of zeros closed by a single one: the window holds
  // exactly one one and every new bit repeats the bit one period earlier.
  always_comb begin
    d = q;
    if (!en_i) begin
      d = '0;
    end else if (bit_valid_i) begin
      d.hist  = {q.hist[PERIOD-2:0], bit_i};
      d.match = (q.hist != '0) && ((q.hist & (q.hist - 1'b1)) == '0) &&
                (bit_i == q.hist[PERIOD-1]);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign match_o = q.match;

endmodule

// [src/tlc_qual_timer.sv]
`timescale 1ns/1ps
module tlc_qual_timer #(
  parameter logic [31:0] LIMIT = 32'h0000_0010
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rstn_i,
  // Raw match and qualified result
  input  wire logic match_i,
  output logic      qual_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        qual;
  } tlc_tmr_state_s;

  tlc_tmr_state_s q;
  tlc_tmr_state_s d;

  // Any break in the pattern restarts the full persistence interval.
  always_comb begin
    d = q;
    if (!match_i) begin
      d = '0;
    end else if (q.cnt >= LIMIT) begin
      d.qual = 1'b1;
    end else begin
      d.cnt = q.cnt + 32'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign qual_o = q.qual;

endmodule

// [src/tlc_top.sv]
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module tlc_top #(
  parameter logic [31:0] LOOP_QUAL_CYCLES = tlc_pkg::LOOP_QUAL_CYCLES
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Register port
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [7:0]  reg_rdata_o,
  // Receive line
  input  wire logic        rx_bit_valid_i,
  input  wire logic        rx_data_i,
  // Transmit line
  input  wire logic        transmit_clock_i,
  input  wire logic        tx_data_i,
  output logic             tx_data_o,
  // Line control
  output logic             remote_loopback_o,
  output logic             line_code_ami_o,
  // Interrupt
  output logic             irq_o
);

  // ===========================================================================
  // State
  // ===========================================================================
  typedef struct packed {
    logic [7:0]         cfg;
    logic [7:0]         ctrl3;
    logic [7:0]         irq_en;
    logic [7:0]         irq_sts;
    logic [7:0]         rdata;
    tlc_pkg::tlc_auto_e auto_st;
    logic               det;
    logic               tclk;
    logic               ins;
    logic               txd;
  } tlc_top_state_s;

  tlc_top_state_s q;
  tlc_top_state_s d;

  tlc_pkg::tlc_det_sel_e det_sel;
  logic                  qrss_sel;
  logic                  up_en;
  logic                  down_en;
  logic                  up_match;
  logic                  down_match;
  logic                  up_qual;
  logic                  down_qual;
  logic                  tclk_rise;
  logic                  det_next;

  assign det_sel  = tlc_pkg::tlc_det_sel_e'(q.ctrl3[tlc_pkg::CTRL3_DET_SEL_LSB +: 2]);
  assign qrss_sel = (q.cfg[2:0] == tlc_pkg::PAT_QRSS);

  // ===========================================================================
  // Detector enables
  // ===========================================================================
  // Only one detector runs at a time, so a stale count from the other code
  // can never leak into the status after a mode change.
  always_comb begin
    up_en   = 1'b0;
    down_en = 1'b0;
    case (det_sel)
      tlc_pkg::DET_OFF: begin
        up_en   = 1'b0;
        down_en = 1'b0;
      end
      tlc_pkg::DET_UP: begin
        up_en = 1'b1;
      end
      tlc_pkg::DET_DOWN: begin
        down_en = 1'b1;
      end
      tlc_pkg::DET_AUTO: begin
        up_en   = (q.auto_st != tlc_pkg::AUTO_LOOPED);
        down_en = (q.auto_st == tlc_pkg::AUTO_LOOPED);
      end
      default: begin
        up_en   = 1'b0;
        down_en = 1'b0;
      end
    endcase
  end

  // ===========================================================================
  // Pattern detection and persistence
  // ===========================================================================
  tlc_pattern_det #(
    .PERIOD (tlc_pkg::LOOP_UP_PERIOD)
  ) u_up_det (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .en_i        (up_en),
    .bit_valid_i (rx_bit_valid_i),
    .bit_i       (rx_data_i),
    .match_o     (up_match)
  );

  tlc_pattern_det #(
    .PERIOD (tlc_pkg::LOOP_DOWN_PERIOD)
  ) u_down_det (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .en_i        (down_en),
    .bit_valid_i (rx_bit_valid_i),
    .bit_i       (rx_data_i),
    .match_o     (down_match)
  );

  tlc_qual_timer #(
    .LIMIT (LOOP_QUAL_CYCLES)
  ) u_up_tmr (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .match_i (up_match),
    .qual_o  (up_qual)
  );

  tlc_qual_timer #(
    .LIMIT (LOOP_QUAL_CYCLES)
  ) u_down_tmr (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .match_i (down_match),
    .qual_o  (down_qual)
  );

  assign tclk_rise = transmit_clock_i & ~q.tclk;

  // ===========================================================================
  // Next state
  // ===========================================================================
  always_comb begin
    d        = q;
    det_next = 1'b0;

    // Automatic loop-back sequencer.
    case (q.auto_st)
      tlc_pkg::AUTO_OFF: begin
        if (det_sel == tlc_pkg::DET_AUTO) begin
          d.auto_st = tlc_pkg::AUTO_HUNT;
        end
      end
      tlc_pkg::AUTO_HUNT: begin
        if (det_sel != tlc_pkg::DET_AUTO) begin
          d.auto_st = tlc_pkg::AUTO_OFF;
        end else if (up_qual) begin
          d.auto_st = tlc_pkg::AUTO_LOOPED;
        end
      end
      tlc_pkg::AUTO_LOOPED: begin
        if (det_sel != tlc_pkg::DET_AUTO) begin
          d.auto_st = tlc_pkg::AUTO_OFF;
        end else if (down_qual) begin
          d.auto_st = tlc_pkg::AUTO_HUNT;
        end
      end
      default: begin
        d.auto_st = tlc_pkg::AUTO_OFF;
      end
    endcase

    // Detected status per mode.
    case (det_sel)
      tlc_pkg::DET_UP:   det_next = up_qual;
      tlc_pkg::DET_DOWN: det_next = down_qual;
      tlc_pkg::DET_AUTO: det_next = (q.auto_st == tlc_pkg::AUTO_LOOPED);
      default:           det_next = 1'b0;
    endcase
    d.det = det_next;

    // Register writes; the change event below is applied after the clear.
    if (reg_wr_i) begin
      case (reg_addr_i)
        tlc_pkg::ADDR_LINE_CFG: d.cfg    = reg_wdata_i & tlc_pkg::CFG_MASK;
        tlc_pkg::ADDR_CTRL3:    d.ctrl3  = reg_wdata_i;
        tlc_pkg::ADDR_IRQ_EN:   d.irq_en = reg_wdata_i & tlc_pkg::LOOP_MASK;
        tlc_pkg::ADDR_IRQ_STS:  d.irq_sts = q.irq_sts & ~reg_wdata_i;
        default: begin
        end
      endcase
    end

    // Both the onset and the loss of detection are events; set wins over clear.
    if (det_next != q.det) begin
      d.irq_sts[tlc_pkg::LOOP_BIT] = 1'b1;
    end

    // Read data stands only in the cycle after the strobe.
    d.rdata = tlc_pkg::RDATA_IDLE;
    if (reg_rd_i) begin
      case (reg_addr_i)
        tlc_pkg::ADDR_LINE_CFG: d.rdata = q.cfg;
        tlc_pkg::ADDR_CTRL3:    d.rdata = q.ctrl3;
        tlc_pkg::ADDR_IRQ_EN:   d.rdata = q.irq_en;
        tlc_pkg::ADDR_STATUS:   d.rdata = 8'(q.det) << tlc_pkg::LOOP_BIT;
        tlc_pkg::ADDR_IRQ_STS:  d.rdata = q.irq_sts;
        default:                d.rdata = tlc_pkg::RDATA_IDLE;
      endcase
    end

    // Error insertion runs on transmit clock edges seen in this domain. The
    // insert bit is sampled even outside QRSS so that a one left standing
    // from another pattern cannot fire later.
    d.tclk = transmit_clock_i;
    if (tclk_rise) begin
      d.ins = q.ctrl3[tlc_pkg::CTRL3_INS_ERR];
      d.txd = tx_data_i ^ (qrss_sel & q.ctrl3[tlc_pkg::CTRL3_INS_ERR] & ~q.ins);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ===========================================================================
  // Outputs
  // ===========================================================================
  assign reg_rdata_o       = q.rdata;
  assign tx_data_o         = q.txd;
  assign remote_loopback_o = (q.auto_st == tlc_pkg::AUTO_LOOPED);
  assign line_code_ami_o   = q.cfg[tlc_pkg::CFG_SINGLE_RAIL] &
                             q.ctrl3[tlc_pkg::CTRL3_LINE_CODE];
  assign irq_o             = |(q.irq_sts & q.irq_en);

  // ===========================================================================
  // Assertions
  // ===========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_up_lost;
    (det_sel == tlc_pkg::DET_UP && !up_match) [*3];
  endsequence

  sequence s_down_lost;
    (det_sel == tlc_pkg::DET_DOWN && !down_match) [*3];
  endsequence

  sequence s_err_edge;
    tclk_rise && qrss_sel && q.ctrl3[tlc_pkg::CTRL3_INS_ERR] && !q.ins;
  endsequence

  AST_OFF_NO_DET: assert property (
    det_sel == tlc_pkg::DET_OFF && $past(det_sel) == tlc_pkg::DET_OFF |-> !q.det)
    else $error("Detection reported while disabled.");

  AST_UP_ONLY: assert property (
    det_sel == tlc_pkg::DET_UP |-> up_en && !down_en)
    else $error("Loop-down detector active in loop-up mode.");

  AST_DOWN_ONLY: assert property (
    det_sel == tlc_pkg::DET_DOWN |-> down_en && !up_en)
    else $error("Loop-up detector active in loop-down mode.");

  AST_AUTO_LOOP: assert property (
    det_sel == tlc_pkg::DET_AUTO && q.auto_st == tlc_pkg::AUTO_HUNT && up_qual
    |=> remote_loopback_o)
    else $error("Remote loop-back not activated on qualified loop-up.");

  AST_UP_PERSIST: assert property (
    s_up_lost |-> !q.det)
    else $error("Loop-up reported without a persisting pattern.");

  AST_DOWN_PERSIST: assert property (
    s_down_lost |-> !q.det)
    else $error("Loop-down reported without a persisting pattern.");

  AST_CHANGE_FLAG: assert property (
    $changed(q.det) |-> q.irq_sts[tlc_pkg::LOOP_BIT])
    else $error("Detection change did not set the interrupt flag.");

  AST_IRQ_GATE: assert property (
    !q.irq_en[tlc_pkg::LOOP_BIT] |-> !irq_o)
    else $error("Interrupt raised while disabled.");

  AST_AUTO_HOLD: assert property (
    q.auto_st == tlc_pkg::AUTO_LOOPED && det_sel == tlc_pkg::DET_AUTO && !down_qual
    |=> q.det && remote_loopback_o)
    else $error("Loop-back released before loop-down qualified.");

  AST_RAIL_IGNORE: assert property (
    !q.cfg[tlc_pkg::CFG_SINGLE_RAIL] |-> !line_code_ami_o)
    else $error("Line code select acted outside single-rail mode.");

  AST_ERR_INSERT: assert property (
    s_err_edge |=> tx_data_o != $past(tx_data_i))
    else $error("Bit error not inserted on insert edge.");

  AST_ERR_SINGLE: assert property (
    tclk_rise && q.ins |=> tx_data_o == $past(tx_data_i))
    else $error("Bit error inserted without a fresh insert edge.");

  AST_UP_QUAL_DET: assert property (
    det_sel == tlc_pkg::DET_UP && up_qual |=> q.det)
    else $error("Qualified loop-up not reported.");

  AST_DOWN_QUAL_DET: assert property (
    det_sel == tlc_pkg::DET_DOWN && down_qual |=> q.det)
    else $error("Qualified loop-down not reported.");

  AST_STATUS_READ: assert property (
    reg_rd_i && reg_addr_i == tlc_pkg::ADDR_STATUS |=>
    reg_rdata_o[tlc_pkg::LOOP_BIT] == $past(q.det))
    else $error("Status read does not show the detected flag.");

  AST_AUTO_RELEASE: assert property (
    det_sel == tlc_pkg::DET_AUTO && q.auto_st == tlc_pkg::AUTO_LOOPED && down_qual
    |=> !remote_loopback_o)
    else $error("Loop-back kept after loop-down qualified.");

  AST_ERR_NOT_QRSS: assert property (
    tclk_rise && !qrss_sel |=> tx_data_o == $past(tx_data_i))
    else $error("Bit error inserted outside the QRSS pattern.");

  // Read data must fall back to idle so a stale value is never taken twice.
  AST_RDATA_IDLE: assert property (
    !reg_rd_i |=> reg_rdata_o == tlc_pkg::RDATA_IDLE)
    else $error("Read data stood longer than one cycle.");

endmodule

// [verification/tlc_line_model.sv]
`timescale 1ns/1ps
module tlc_line_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Pattern choice: 0 all ones, 1 loop-up code, 2 loop-down code
  input  wire logic [1:0] pat_sel_i,
  // Receive line towards the block
  output logic            rx_bit_valid_o,
  output logic            rx_data_o,
  // Transmit clock and data towards the block
  output logic            transmit_clock_o,
  output logic            tx_data_o
);
  logic [2:0] phase_q;
  logic [1:0] pat_q;
  logic [4:0] tdiv_q;

  // ==========================================================================
  // Transmit side
  // ==========================================================================
  // The transmit clock runs free at an eighth of the system clock.
  assign transmit_clock_o = tdiv_q[2];
  assign tx_data_o        = tdiv_q[3] ^ tdiv_q[4];

  // ==========================================================================
  // Receive side
  // ==========================================================================
  // A pattern change restarts the phase, so a new code starts cleanly.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_q        <= 3'h0;
      pat_q          <= 2'h0;
      tdiv_q         <= 5'h00;
      rx_bit_valid_o <= 1'b0;
      rx_data_o      <= 1'b1;
    end else begin
      tdiv_q         <= tdiv_q + 5'h01;
      pat_q          <= pat_sel_i;
      rx_bit_valid_o <= ~rx_bit_valid_o;
      if (pat_q != pat_sel_i) begin
        phase_q <= 3'h0;
      end else if (!rx_bit_valid_o) begin
        case (pat_q)
          2'h1: begin
            rx_data_o <= (phase_q == 3'h4);
            phase_q   <= (phase_q == 3'h4) ? 3'h0 : phase_q + 3'h1;
          end
          2'h2: begin
            rx_data_o <= (phase_q == 3'h2);
            phase_q   <= (phase_q == 3'h2) ? 3'h0 : phase_q + 3'h1;
          end
          default: begin
            rx_data_o <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// [verification/tlc_top_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tlc_top_tb;
  logic        clk_i        = 1'b0;
  logic        rstn_i       = 1'b0;
  logic [15:0] addr         = 16'h0000;
  logic [7:0]  wdata        = 8'h00;
  logic        wr           = 1'b0;
  logic        rd_s         = 1'b0;
  logic [1:0]  pat          = 2'h0;
  logic [7:0]  rdata;
  logic [7:0]  d;
  logic        rxv, rxd, tclk, txd, txo, lb, ami, irq;
  logic        tclk_p       = 1'b0;
  logic        tx_exp       = 1'b0;
  logic        flip_p       = 1'b0;
  int          n_flips      = 0;
  int          n_mismatch   = 0;
  int          total_checks = 0;

  always #2 clk_i = ~clk_i;

  tlc_top #(.LOOP_QUAL_CYCLES(32'd20)) tlc_top_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd_s), .reg_rdata_o(rdata), .rx_bit_valid_i(rxv),
    .rx_data_i(rxd), .transmit_clock_i(tclk), .tx_data_i(txd), .tx_data_o(txo),
    .remote_loopback_o(lb), .line_code_ami_o(ami), .irq_o(irq));

  tlc_line_model tlc_line_model_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .pat_sel_i(pat), .rx_bit_valid_o(rxv),
    .rx_data_o(rxd), .transmit_clock_o(tclk), .tx_data_o(txd));

  // ==========================================================================
  // Transmit shadow: counts each stretch where the sent bit differs
  // ==========================================================================
  always @(posedge clk_i) begin
    tclk_p <= tclk;
    if (tclk && !tclk_p) tx_exp <= txd;
    flip_p <= (txo !== tx_exp);
    if ((txo !== tx_exp) && !flip_p) n_flips++;
  end

  // ==========================================================================
  // Bus tasks
  // ==========================================================================
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_i);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask

  // Waiting off the edge keeps counters and flags settled when read.
  task automatic quiet(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wait_det(input logic [7:0] e, output logic [7:0] v);
    for (int i = 0; i < 150; i++) begin
      rd_reg(tlc_pkg::ADDR_STATUS, v);
      v = v & tlc_pkg::LOOP_MASK;
      if (v === e) break;
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_regs();
    rd_reg(tlc_pkg::ADDR_CTRL3, d);
    `CHK(d, tlc_pkg::RST_VAL)
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h3c);
    rd_reg(tlc_pkg::ADDR_CTRL3, d);
    `CHK(d, 8'h3c)
    rd_reg(16'h0f07, d);
    `CHK(d, tlc_pkg::RDATA_IDLE)
    wr_reg(tlc_pkg::ADDR_LINE_CFG, 8'hff);
    wr_reg(tlc_pkg::ADDR_IRQ_EN, 8'hff);
    rd_reg(tlc_pkg::ADDR_LINE_CFG, d);
    `CHK(d, tlc_pkg::CFG_MASK)
    rd_reg(tlc_pkg::ADDR_IRQ_EN, d);
    `CHK(d, tlc_pkg::LOOP_MASK)
    wr_reg(tlc_pkg::ADDR_LINE_CFG, 8'h00);
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h00);
  endtask

  task automatic t_off();
    wr_reg(tlc_pkg::ADDR_IRQ_EN, tlc_pkg::LOOP_MASK);
    pat <= 2'h1;
    quiet(150);
    rd_reg(tlc_pkg::ADDR_STATUS, d);
    `CHK(d, 8'h00)
    `CHK(irq, 1'b0)
  endtask

  task automatic t_up();
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h40);
    quiet(20);
    rd_reg(tlc_pkg::ADDR_STATUS, d);
    `CHK(d, 8'h00)
    wait_det(tlc_pkg::LOOP_MASK, d);
    `CHK(d, tlc_pkg::LOOP_MASK)
    `CHK(irq, 1'b1)
    wr_reg(tlc_pkg::ADDR_IRQ_STS, tlc_pkg::LOOP_MASK);
    quiet(2);
    `CHK(irq, 1'b0)
    pat <= 2'h2;
    wait_det(8'h00, d);
    `CHK(d, 8'h00)
    `CHK(irq, 1'b1)
    wr_reg(tlc_pkg::ADDR_IRQ_STS, tlc_pkg::LOOP_MASK);
    quiet(150);
    rd_reg(tlc_pkg::ADDR_STATUS, d);
    `CHK(d, 8'h00)
  endtask

  task automatic t_down();
    wr_reg(tlc_pkg::ADDR_IRQ_EN, 8'h00);
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h80);
    wait_det(tlc_pkg::LOOP_MASK, d);
    `CHK(d, tlc_pkg::LOOP_MASK)
    rd_reg(tlc_pkg::ADDR_IRQ_STS, d);
    `CHK(d, tlc_pkg::LOOP_MASK)
    `CHK(irq, 1'b0)
    pat <= 2'h1;
    wait_det(8'h00, d);
    quiet(150);
    rd_reg(tlc_pkg::ADDR_STATUS, d);
    `CHK(d, 8'h00)
    wr_reg(tlc_pkg::ADDR_IRQ_STS, tlc_pkg::LOOP_MASK);
  endtask

  task automatic t_auto();
    wr_reg(tlc_pkg::ADDR_IRQ_EN, tlc_pkg::LOOP_MASK);
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'hc0);
    wait_det(tlc_pkg::LOOP_MASK, d);
    `CHK(d, tlc_pkg::LOOP_MASK)
    `CHK(lb, 1'b1)
    pat <= 2'h0;
    quiet(150);
    rd_reg(tlc_pkg::ADDR_STATUS, d);
    `CHK(d, tlc_pkg::LOOP_MASK)
    `CHK(lb, 1'b1)
    pat <= 2'h2;
    wait_det(8'h00, d);
    `CHK(d, 8'h00)
    `CHK(lb, 1'b0)
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h00);
    wr_reg(tlc_pkg::ADDR_IRQ_STS, tlc_pkg::LOOP_MASK);
  endtask

  task automatic t_line();
    wr_reg(tlc_pkg::ADDR_LINE_CFG, 8'h08);
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h20);
    quiet(2);
    `CHK(ami, 1'b1)
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h00);
    quiet(2);
    `CHK(ami, 1'b0)
    wr_reg(tlc_pkg::ADDR_LINE_CFG, 8'h00);
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h20);
    quiet(2);
    `CHK(ami, 1'b0)
  endtask

  task automatic t_err();
    int b;
    wr_reg(tlc_pkg::ADDR_LINE_CFG, 8'h04);
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h00);
    b = n_flips;
    quiet(20);
    `CHK(n_flips - b, 0)
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h02);
    quiet(40);
    `CHK(n_flips - b, 1)
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h02);
    quiet(40);
    `CHK(n_flips - b, 1)
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h00);
    quiet(20);
    wr_reg(tlc_pkg::ADDR_LINE_CFG, 8'h03);
    wr_reg(tlc_pkg::ADDR_CTRL3, 8'h02);
    quiet(40);
    `CHK(n_flips - b, 1)
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #80000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    t_regs();
    t_off();
    t_up();
    t_down();
    t_auto();
    t_line();
    t_err();
    finish_test();
  end
endmodule
